// File: spm_pin_control.sv
// spm_pin_control: shared pin function, pull, drive and mode control
// assumes all inputs synchronous to clk_sys; rst is the chip power-on reset
`timescale 1ns/10ps
module spm_pin_control
   import spm_pkg::*;
(
   // clock and reset
   input  wire logic                clk_sys,
   input  wire logic                rst,
   // option controls
   input  wire logic                resetPinEnableSet,
   input  wire logic                debugPinEnableClear,
   input  wire logic                debugForceReset,
   input  wire logic                timerCaptureEnable,
   input  wire logic                timerCompareEnable,
   input  wire logic                timerCompareOut,
   input  wire logic                irqPinEnable,
   input  wire logic                irqPullDisable,
   input  wire logic                irqRisingEdge,
   // per-pin software controls
   input  wire logic [NUM_PINS-1:0] pullEnableReg,
   input  wire logic [NUM_PINS-1:0] driveHighReg,
   input  wire logic [NUM_PINS-1:0] slewEnableReg,
   input  wire logic [NUM_PINS-1:0] outputEnableReg,
   input  wire logic [NUM_PINS-1:0] keyboardPinEnable,
   input  wire logic [NUM_PINS-1:0] keyboardEdgeSelect,
   input  wire logic                outOnlyEnable,
   // debug serializer
   input  wire logic                debugTxActive,
   input  wire logic                debugTxLevel,
   // pin inputs
   input  wire logic                resetPinIn,
   input  wire logic                debugPinIn,
   // pin outputs
   output logic                     debugPinOut,
   output logic                     debugPinOutEnN,
   output logic [NUM_PINS-1:0]      pullUpOn,
   output logic [NUM_PINS-1:0]      pullDownOn,
   output logic [NUM_PINS-1:0]      driveHigh,
   output logic [NUM_PINS-1:0]      slewEnable,
   output logic                     outOnlyActive,
   // status and routed functions
   output logic                     resetPinEnable,
   output logic                     debugPinEnable,
   output logic                     backgroundMode,
   output logic                     chipReset,
   output logic                     timerCaptureIn,
   output logic                     gpioResetPinIn,
   output logic                     debugRxLevel,
   output logic                     debugBitTick,
   output logic [2:0]               busClockDiv
);

   spm_rst_state_t state;
   spm_rst_state_t next_state;
   spm_mode_t      mode;
   spm_mode_t      next_mode;
   logic           next_resetPinEnable;
   logic           next_debugPinEnable;
   logic           next_chipReset;
   logic           forcedPending;
   logic           next_forcedPending;
   logic           porDone;
   logic           next_porDone;
   logic [4:0]     bitCnt;
   logic [4:0]     next_bitCnt;
   logic           next_debugBitTick;
   logic [2:0]     next_busClockDiv;
   logic [NUM_PINS-1:0] next_pullUpOn;
   logic [NUM_PINS-1:0] next_pullDownOn;
   logic [NUM_PINS-1:0] next_driveHigh;
   logic [NUM_PINS-1:0] next_slewEnable;
   logic           next_outOnlyActive;
   logic           next_timerCaptureIn;
   logic           next_gpioResetPinIn;
   logic           next_debugRxLevel;
   logic           txOut;
   logic           txOutEnN;
   logic           next_backgroundMode;
   logic           next_debugPinOut;
   logic           next_debugPinOutEnN;

   // a pin counts as output when port or a peripheral drives it; never the reset pin, and pin OUT_ONLY_IDX only by outOnlyEnable
   function automatic logic pinIsOutput(input int idx, input logic [NUM_PINS-1:0] oe,
                                        input logic dbgEn, input logic cmpEn, input logic ooEn);
      logic r;
      r = oe[idx];
      if (idx == DEBUG_PIN_IDX)
         r = !dbgEn && (cmpEn || oe[idx]);
      if (idx == RESET_PIN_IDX)
         r = 1'b0;
      if (idx == OUT_ONLY_IDX)
         r = ooEn;
      return r;
   endfunction

   // reset sequencing, mode sampling and sticky option bits
   always_comb
   begin
      next_state          = state;
      next_mode           = mode;
      next_resetPinEnable = resetPinEnable;
      next_debugPinEnable = debugPinEnable;
      next_chipReset      = 1'b0;
      next_forcedPending  = 1'b0;
      next_porDone        = porDone;
      if (resetPinEnableSet)
         next_resetPinEnable = 1'b1;
      if (debugPinEnableClear)
         next_debugPinEnable = 1'b0;
      case (state)
         SPM_RS_IDLE:
         begin
            if (!porDone)
            begin
               next_state     = SPM_RS_SAMPLE;
               next_chipReset = 1'b1;
            end
            else if (debugForceReset)
            begin
               next_state         = SPM_RS_HOLD;
               next_forcedPending = 1'b1;
               next_chipReset     = 1'b1;
            end
            else if (resetPinEnable && !resetPinIn)
            begin
               next_state     = SPM_RS_HOLD;
               next_chipReset = 1'b1;
            end
         end
         SPM_RS_HOLD:
         begin
            next_chipReset      = 1'b1;
            next_forcedPending  = forcedPending;
            next_debugPinEnable = 1'b1;
            if (forcedPending)
               next_state = SPM_RS_SAMPLE;
            else if (resetPinIn)
            begin
               next_state     = SPM_RS_IDLE;
               next_mode      = SPM_MODE_RUN;
               next_chipReset = 1'b0;
            end
         end
         SPM_RS_SAMPLE:
         begin
            // pin high at reset release gives run mode
            next_mode           = debugPinIn ? SPM_MODE_RUN : SPM_MODE_BACKGROUND;
            next_debugPinEnable = 1'b1;
            if (!porDone && !debugPinIn)
               next_resetPinEnable = 1'b1;
            next_state = SPM_RS_IDLE;
            next_porDone = 1'b1;
         end
         default:
            next_state = SPM_RS_IDLE;
      endcase
      next_backgroundMode = (next_mode == SPM_MODE_BACKGROUND);
   end

   always_ff @(posedge clk_sys)
   begin
      if (rst)
      begin
         state          <= SPM_RS_IDLE;
         mode           <= SPM_MODE_RUN;
         resetPinEnable <= RESET_PIN_EN_RST;
         debugPinEnable <= DEBUG_PIN_EN_RST;
         chipReset      <= 1'b1;
         forcedPending  <= 1'b0;
         porDone        <= 1'b0;
         backgroundMode <= 1'b0;
      end
      else
      begin
         state          <= next_state;
         mode           <= next_mode;
         resetPinEnable <= next_resetPinEnable;
         debugPinEnable <= next_debugPinEnable;
         chipReset      <= next_chipReset;
         forcedPending  <= next_forcedPending;
         porDone        <= next_porDone;
         backgroundMode <= next_backgroundMode;
      end
   end

   // pad controls per pin
   always_comb
   begin
      for (int i = 0; i < NUM_PINS; i++)
      begin
         next_driveHigh[i]  = driveHighReg[i];
         next_slewEnable[i] = slewEnableReg[i];
         next_pullUpOn[i]   = pullEnableReg[i];
         next_pullDownOn[i] = 1'b0;
         if (keyboardPinEnable[i] && pullEnableReg[i] && keyboardEdgeSelect[i])
         begin
            next_pullUpOn[i]   = 1'b0;
            next_pullDownOn[i] = 1'b1;
         end
         if (pinIsOutput(i, outputEnableReg, debugPinEnable, timerCompareEnable, outOnlyEnable))
         begin
            next_pullUpOn[i]   = 1'b0;
            next_pullDownOn[i] = 1'b0;
         end
      end
      if (resetPinEnable)
      begin
         next_pullUpOn[RESET_PIN_IDX]   = 1'b1;
         next_pullDownOn[RESET_PIN_IDX] = 1'b0;
      end
      else if (irqPinEnable)
      begin
         next_pullUpOn[RESET_PIN_IDX]   = !irqPullDisable && !irqRisingEdge;
         next_pullDownOn[RESET_PIN_IDX] = !irqPullDisable && irqRisingEdge;
      end
      if (debugPinEnable)
      begin
         next_pullUpOn[DEBUG_PIN_IDX]   = 1'b1;
         next_pullDownOn[DEBUG_PIN_IDX] = 1'b0;
      end
      next_outOnlyActive  = outOnlyEnable;
      next_timerCaptureIn = (timerCaptureEnable && !resetPinEnable) ? resetPinIn : 1'b0;
      next_gpioResetPinIn = resetPinEnable ? 1'b0 : resetPinIn;
      next_debugRxLevel   = debugPinEnable ? debugPinIn : 1'b1;
      next_busClockDiv    = BUS_DIV_LAST;
   end

   always_ff @(posedge clk_sys)
   begin
      if (rst)
      begin
         pullUpOn       <= {NUM_PINS{PULL_EN_RST}};
         pullDownOn     <= '0;
         driveHigh      <= {NUM_PINS{DRIVE_HIGH_RST}};
         slewEnable     <= {NUM_PINS{SLEW_EN_RST}};
         outOnlyActive  <= 1'b0;
         timerCaptureIn <= 1'b0;
         gpioResetPinIn <= 1'b0;
         debugRxLevel   <= 1'b1;
         busClockDiv    <= BUS_DIV_LAST;
         debugPinOut    <= 1'b1;
         debugPinOutEnN <= 1'b1;
      end
      else
      begin
         pullUpOn       <= next_pullUpOn;
         pullDownOn     <= next_pullDownOn;
         driveHigh      <= next_driveHigh;
         slewEnable     <= next_slewEnable;
         outOnlyActive  <= next_outOnlyActive;
         timerCaptureIn <= next_timerCaptureIn;
         gpioResetPinIn <= next_gpioResetPinIn;
         debugRxLevel   <= next_debugRxLevel;
         busClockDiv    <= next_busClockDiv;
         debugPinOut    <= next_debugPinOut;
         debugPinOutEnN <= next_debugPinOutEnN;
      end
   end

   // debug bit-time counter
   always_comb
   begin
      next_bitCnt       = 5'h00;
      next_debugBitTick = 1'b0;
      if (debugPinEnable && debugTxActive)
      begin
         next_bitCnt = (bitCnt == DEBUG_BIT_LAST) ? 5'h00 : bitCnt + 5'h01;
         next_debugBitTick = (bitCnt == DEBUG_BIT_LAST);
      end
   end

   always_ff @(posedge clk_sys)
   begin
      if (rst)
      begin
         bitCnt       <= 5'h00;
         debugBitTick <= 1'b0;
      end
      else
      begin
         bitCnt       <= next_bitCnt;
         debugBitTick <= next_debugBitTick;
      end
   end

   spm_speedup u_speedup (
      .clk_sys   (clk_sys),
      .rst       (rst),
      .active    (debugPinEnable && debugTxActive),
      .txLevel   (debugTxLevel),
      .pinOut    (txOut),
      .pinOutEnN (txOutEnN)
   );

   // pin owner: debug link when enabled, else timer compare output
   always_comb
   begin
      next_debugPinOut    = txOut;
      next_debugPinOutEnN = txOutEnN;
      if (!debugPinEnable)
      begin
         next_debugPinOut    = timerCompareOut;
         next_debugPinOutEnN = !(timerCompareEnable || outputEnableReg[DEBUG_PIN_IDX]);
      end
   end

endmodule

// File: spm_pkg.sv
// spm_pkg: constants for the shared-pin reset and mode control block
// assumes a single 125 MHz system clock; no register bus, all controls are ports
package spm_pkg;

   localparam int          NUM_PINS          = 6;
   localparam int          RESET_PIN_IDX     = 5;
   localparam int          DEBUG_PIN_IDX     = 4;
   localparam int          OUT_ONLY_IDX      = 2;

   // debug link bit time in system clocks
   localparam int          DEBUG_BIT_CLOCKS  = 16;
   localparam logic [4:0]  DEBUG_BIT_LAST    = 5'h0F;

   // internal clock source and default bus divider
   localparam int          SRC_NOMINAL_MHZ   = 16;
   localparam int          BUS_DEFAULT_MHZ   = 4;
   localparam int          BUS_DIV_DEFAULT   = SRC_NOMINAL_MHZ / BUS_DEFAULT_MHZ;
   localparam logic [2:0]  BUS_DIV_LAST      = 3'(BUS_DIV_DEFAULT - 1);

   // speedup pulse length in system clocks, less one
   localparam logic [1:0]  SPEEDUP_LAST      = 2'h1;

   // reset values
   localparam logic        RESET_PIN_EN_RST  = 1'b0;
   localparam logic        DEBUG_PIN_EN_RST  = 1'b1;
   localparam logic        DRIVE_HIGH_RST    = 1'b0;
   localparam logic        SLEW_EN_RST       = 1'b1;
   localparam logic        PULL_EN_RST       = 1'b0;

   typedef enum logic [1:0] {
      SPM_MODE_RUN,
      SPM_MODE_BACKGROUND
   } spm_mode_t;

   typedef enum logic [1:0] {
      SPM_RS_IDLE,
      SPM_RS_HOLD,
      SPM_RS_SAMPLE
   } spm_rst_state_t;

endpackage

// File: spm_speedup.sv
// spm_speedup: pseudo open-drain driver for the debug pin with speedup pulse
// assumes the debug serializer gives a level to send on clk_sys
`timescale 1ns/10ps
module spm_speedup
   import spm_pkg::*;
(
   // clock and reset
   input  wire logic clk_sys,
   input  wire logic rst,
   // line request
   input  wire logic active,
   input  wire logic txLevel,
   // pin controls
   output logic      pinOut,
   output logic      pinOutEnN
);

   logic       prevLevel;
   logic [1:0] pulseCnt;
   logic       next_prevLevel;
   logic [1:0] next_pulseCnt;
   logic       next_pinOut;
   logic       next_pinOutEnN;

   // low is driven, a step from low to high is a brief driven pulse then released
   always_comb
   begin
      next_prevLevel = active ? txLevel : 1'b1;
      next_pulseCnt  = pulseCnt;
      next_pinOut    = 1'b1;
      next_pinOutEnN = 1'b1;
      if (active && !txLevel)
      begin
         next_pinOut    = 1'b0;
         next_pinOutEnN = 1'b0;
         next_pulseCnt  = 2'h0;
      end
      else if (active && txLevel && !prevLevel)
      begin
         next_pinOutEnN = 1'b0;
         next_pulseCnt  = SPEEDUP_LAST;
      end
      else if (pulseCnt != 2'h0)
      begin
         next_pinOutEnN = 1'b0;
         next_pulseCnt  = pulseCnt - 2'h1;
      end
   end

   always_ff @(posedge clk_sys)
   begin
      if (rst)
      begin
         prevLevel <= 1'b1;
         pulseCnt  <= 2'h0;
         pinOut    <= 1'b1;
         pinOutEnN <= 1'b1;
      end
      else
      begin
         prevLevel <= next_prevLevel;
         pulseCnt  <= next_pulseCnt;
         pinOut    <= next_pinOut;
         pinOutEnN <= next_pinOutEnN;
      end
   end

endmodule

// File: spm_pin_control_properties.sv
// spm_checker: timing relations on the ports of spm_pin_control
// assumes one clock domain and a synchronous active-high rst
`timescale 1ns/10ps
module spm_checker
   import spm_pkg::*;
(
   // clock and reset
   input wire logic                clk_sys,
   input wire logic                rst,
   // observed controls and pins
   input wire logic                debugForceReset,
   input wire logic                timerCaptureEnable,
   input wire logic                irqPinEnable,
   input wire logic [NUM_PINS-1:0] driveHighReg,
   input wire logic                resetPinIn,
   input wire logic                debugPinOutEnN,
   // observed results
   input wire logic [NUM_PINS-1:0] pullUpOn,
   input wire logic [NUM_PINS-1:0] driveHigh,
   input wire logic [NUM_PINS-1:0] slewEnable,
   input wire logic                resetPinEnable,
   input wire logic                debugPinEnable,
   input wire logic                chipReset,
   input wire logic                timerCaptureIn,
   input wire logic                debugBitTick,
   input wire logic [2:0]          busClockDiv
);
   default clocking @(posedge clk_sys); endclocking
   default disable iff (rst);
   property p_stick;
      resetPinEnable |=> resetPinEnable;
   endproperty
   a_stick: assert property (p_stick) else $error("reset pin enable dropped");
   property p_rstPull;
      (!rst && resetPinEnable) ##1 resetPinEnable |-> pullUpOn[RESET_PIN_IDX];
   endproperty
   a_rstPull: assert property (p_rstPull) else $error("reset pin pullup off");
   property p_dbgPull;
      (!rst && debugPinEnable && debugPinOutEnN) ##1 (debugPinEnable && debugPinOutEnN) |-> pullUpOn[DEBUG_PIN_IDX];
   endproperty
   a_dbgPull: assert property (p_dbgPull) else $error("debug pin pullup off");
   property p_rstVals;
      disable iff (1'b0) rst |=> debugPinEnable && driveHigh == 6'h00 && slewEnable == 6'h3F
         && (pullUpOn & 6'h2F) == 6'h00;
   endproperty
   a_rstVals: assert property (p_rstVals) else $error("wrong pad state in reset");
   property p_drive;
      !rst |=> ((driveHigh ^ $past(driveHighReg)) & 6'h0B) == 6'h00;
   endproperty
   a_drive: assert property (p_drive) else $error("drive select not applied");
   property p_busDiv;
      busClockDiv == BUS_DIV_LAST;
   endproperty
   a_busDiv: assert property (p_busDiv) else $error("bus divider wrong");
   property p_tick;
      debugBitTick |=> !debugBitTick [*8];
   endproperty
   a_tick: assert property (p_tick) else $error("debug bit tick too soon");
   property p_capture;
      !rst && timerCaptureEnable && !resetPinEnable && !irqPinEnable |=> timerCaptureIn == $past(resetPinIn);
   endproperty
   a_capture: assert property (p_capture) else $error("capture input not routed");
   property p_pinReset;
      !rst && resetPinEnable && !resetPinIn && !chipReset |=> chipReset;
   endproperty
   a_pinReset: assert property (p_pinReset) else $error("reset pin ignored");
   property p_forced;
      !rst && debugForceReset && !chipReset |=> chipReset;
   endproperty
   a_forced: assert property (p_forced) else $error("forced reset ignored");
   c_chipReset: cover property ($rose(chipReset));
   c_tick: cover property (debugBitTick);
   c_stick: cover property (resetPinEnable ##1 !resetPinIn);
endmodule
bind spm_pin_control spm_checker chk (.clk_sys(clk_sys), .rst(rst), .debugForceReset(debugForceReset),
   .timerCaptureEnable(timerCaptureEnable), .irqPinEnable(irqPinEnable), .driveHighReg(driveHighReg),
   .resetPinIn(resetPinIn), .debugPinOutEnN(debugPinOutEnN), .pullUpOn(pullUpOn), .driveHigh(driveHigh),
   .slewEnable(slewEnable), .resetPinEnable(resetPinEnable), .debugPinEnable(debugPinEnable),
   .chipReset(chipReset), .timerCaptureIn(timerCaptureIn), .debugBitTick(debugBitTick),
   .busClockDiv(busClockDiv));

// File: spm_pod.sv
// spm_pod: debug pod and reset source on the two shared pins
// assumes a pullup on the debug wire whenever no party drives it
`timescale 1ns/10ps
module spm_pod
(
   // pod requests
   input  wire logic holdModeLow,
   input  wire logic resetLow,
   // device side of the debug pin
   input  wire logic debugPinOut,
   input  wire logic debugPinOutEnN,
   // resolved pin levels
   output logic      resetPinIn,
   output logic      debugPinIn
);
   assign resetPinIn = !resetLow;
   // pod pulls low, else the driving party or the pullup sets the wire
   assign debugPinIn = holdModeLow ? 1'b0 : (!debugPinOutEnN ? debugPinOut : 1'b1);
endmodule

// File: testbench.sv
// testbench: self-checking bench for spm_pin_control with the pod model
// assumes spm_pkg and spm_pod are compiled first
`timescale 1ns/10ps
`define CHK(nm, e, a) begin num_checks++; if ((a) !== (e)) begin num_errors++; $display("[FAIL] %s exp %h got %h", nm, e, a); end end
module testbench;
   import spm_pkg::*;
   typedef struct {logic [5:0] pe, kpe, kes, oe, dh, se, up, dn;} spm_row_t;
   spm_row_t rows [4] = '{'{6'h0B, 6'h00, 6'h00, 6'h00, 6'h0B, 6'h00, 6'h0B, 6'h00},
      '{6'h0B, 6'h00, 6'h00, 6'h01, 6'h01, 6'h0A, 6'h0A, 6'h00},
      '{6'h0B, 6'h03, 6'h02, 6'h00, 6'h00, 6'h3F, 6'h09, 6'h02},
      '{6'h00, 6'h03, 6'h03, 6'h00, 6'h02, 6'h04, 6'h00, 6'h00}};
   int num_errors = 0, num_checks = 0, n;
   logic clk_sys = 0, rst = 1, holdLow = 0, resetLow = 0;
   logic resetPinEnableSet = 0, debugPinEnableClear = 0, debugForceReset = 0, timerCaptureEnable = 0;
   logic timerCompareEnable = 0, timerCompareOut = 0, outOnlyEnable = 0, debugTxActive = 0, debugTxLevel = 0;
   logic irqPinEnable = 0, irqPullDisable = 0, irqRisingEdge = 0, resetPinIn, debugPinIn;
   logic [5:0] pullEnableReg = 0, driveHighReg = 0, slewEnableReg = 6'h3F, outputEnableReg = 0;
   logic [5:0] keyboardPinEnable = 0, keyboardEdgeSelect = 0, pullUpOn, pullDownOn, driveHigh, slewEnable;
   logic debugPinOut, debugPinOutEnN, outOnlyActive, resetPinEnable, debugPinEnable, backgroundMode;
   logic chipReset, timerCaptureIn, gpioResetPinIn, debugRxLevel, debugBitTick;
   logic [2:0] busClockDiv;
   always #4 clk_sys = ~clk_sys;
   spm_pin_control DUT (.clk_sys, .rst, .resetPinEnableSet, .debugPinEnableClear, .debugForceReset,
      .timerCaptureEnable, .timerCompareEnable, .timerCompareOut, .irqPinEnable, .irqPullDisable,
      .irqRisingEdge, .pullEnableReg, .driveHighReg, .slewEnableReg, .outputEnableReg, .keyboardPinEnable,
      .keyboardEdgeSelect, .outOnlyEnable, .debugTxActive, .debugTxLevel, .resetPinIn, .debugPinIn,
      .debugPinOut, .debugPinOutEnN, .pullUpOn, .pullDownOn, .driveHigh, .slewEnable, .outOnlyActive,
      .resetPinEnable, .debugPinEnable, .backgroundMode, .chipReset, .timerCaptureIn, .gpioResetPinIn,
      .debugRxLevel, .debugBitTick, .busClockDiv);
   spm_pod pod (.holdModeLow(holdLow), .resetLow(resetLow), .debugPinOut(debugPinOut),
      .debugPinOutEnN(debugPinOutEnN), .resetPinIn(resetPinIn), .debugPinIn(debugPinIn));
   task automatic wt(input int k);
      repeat (k) @(posedge clk_sys);
   endtask
   task automatic test_done;
      $display("checks %0d errors %0d", num_checks, num_errors);
      if (num_errors == 0 && num_checks > 0)
         $display("[ PASS ]");
      else
         $display("[ FAIL ]");
      $finish;
   endtask
   task automatic por(input logic low);
      holdLow <= low;
      rst <= 1'b1;
      wt(3);
      rst <= 1'b0;
      wt(6);
      holdLow <= 1'b0;
      wt(2);
   endtask
   // bounded wait for the reset sequence to finish, ends on a falling edge
   task automatic waitIdle;
      int i;
      @(negedge clk_sys);
      for (i = 0; i < 20 && chipReset !== 1'b0; i++)
         @(negedge clk_sys);
      if (i == 20)
      begin
         num_errors++;
         test_done();
      end
   endtask
   initial
   begin
      por(1'b0);
      #1;
      `CHK("resetPinEnable", 1'b0, resetPinEnable)
      `CHK("debugPinEnable", 1'b1, debugPinEnable)
      `CHK("backgroundMode", 1'b0, backgroundMode)
      `CHK("busClockDiv", BUS_DIV_LAST, busClockDiv)
      `CHK("outOnlyActive", 1'b0, outOnlyActive)
      `CHK("driveHigh", 6'h00, driveHigh)
      `CHK("slewEnable", 6'h3F, slewEnable)
      `CHK("pullUpOn", 6'h00, pullUpOn & 6'h2F)
      foreach (rows[i])
      begin
         wt(1);
         pullEnableReg <= rows[i].pe;
         keyboardPinEnable <= rows[i].kpe;
         keyboardEdgeSelect <= rows[i].kes;
         outputEnableReg <= rows[i].oe;
         driveHighReg <= rows[i].dh;
         slewEnableReg <= rows[i].se;
         wt(2);
         #1;
         `CHK("pullUpOn", rows[i].up, pullUpOn & 6'h0B)
         `CHK("pullDownOn", rows[i].dn, pullDownOn & 6'h0B)
         `CHK("driveHigh", rows[i].dh & 6'h0B, driveHigh & 6'h0B)
         `CHK("slewEnable", rows[i].se & 6'h0B, slewEnable & 6'h0B)
      end
      wt(1);
      outOnlyEnable <= 1'b1;
      resetLow <= 1'b1;
      timerCaptureEnable <= 1'b1;
      wt(3);
      #1;
      `CHK("outOnlyActive", 1'b1, outOnlyActive)
      `CHK("gpioResetPinIn", 1'b0, gpioResetPinIn)
      `CHK("chipReset", 1'b0, chipReset)
      `CHK("timerCaptureIn", 1'b0, timerCaptureIn)
      wt(1);
      resetLow <= 1'b0;
      debugTxActive <= 1'b1;
      wt(3);
      #1;
      `CHK("timerCaptureIn", 1'b1, timerCaptureIn)
      `CHK("gpioResetPinIn", 1'b1, gpioResetPinIn)
      `CHK("debugRxLevel", 1'b0, debugRxLevel)
      `CHK("debugPinOutEnN", 1'b0, debugPinOutEnN)
      `CHK("debugPinOut", 1'b0, debugPinOut)
      wt(1);
      timerCaptureEnable <= 1'b0;
      debugTxLevel <= 1'b1;
      irqPinEnable <= 1'b1;
      irqRisingEdge <= 1'b1;
      wt(5);
      #1;
      `CHK("debugPinOutEnN", 1'b1, debugPinOutEnN)
      `CHK("debugPinIn", 1'b1, debugPinIn)
      `CHK("debugRxLevel", 1'b1, debugRxLevel)
      `CHK("pullDownOn5", 1'b1, pullDownOn[RESET_PIN_IDX])
      `CHK("pullUpOn5", 1'b0, pullUpOn[RESET_PIN_IDX])
      n = 0;
      repeat (48)
      begin
         @(negedge clk_sys);
         if (debugBitTick === 1'b1)
            n++;
      end
      `CHK("debugBitTicks", 3, n)
      wt(1);
      debugTxActive <= 1'b0;
      debugPinEnableClear <= 1'b1;
      irqRisingEdge <= 1'b0;
      timerCompareEnable <= 1'b1;
      timerCompareOut <= 1'b1;
      wt(1);
      debugPinEnableClear <= 1'b0;
      wt(2);
      #1;
      `CHK("debugPinEnable", 1'b0, debugPinEnable)
      `CHK("pullUpOn4", 1'b0, pullUpOn[DEBUG_PIN_IDX])
      `CHK("debugPinOut", 1'b1, debugPinOut)
      `CHK("debugPinOutEnN", 1'b0, debugPinOutEnN)
      `CHK("pullUpOn5", 1'b1, pullUpOn[RESET_PIN_IDX])
      `CHK("pullDownOn5", 1'b0, pullDownOn[RESET_PIN_IDX])
      wt(1);
      timerCompareEnable <= 1'b0;
      irqPullDisable <= 1'b1;
      holdLow <= 1'b1;
      debugForceReset <= 1'b1;
      wt(1);
      debugForceReset <= 1'b0;
      wt(8);
      holdLow <= 1'b0;
      waitIdle();
      `CHK("backgroundMode", 1'b1, backgroundMode)
      `CHK("pullUpOn5", 1'b0, pullUpOn[RESET_PIN_IDX])
      `CHK("pullDownOn5", 1'b0, pullDownOn[RESET_PIN_IDX])
      `CHK("debugPinEnable", 1'b1, debugPinEnable)
      wt(1);
      resetPinEnableSet <= 1'b1;
      wt(1);
      resetPinEnableSet <= 1'b0;
      wt(3);
      #1;
      `CHK("resetPinEnable", 1'b1, resetPinEnable)
      `CHK("pullUpOn5", 1'b1, pullUpOn[RESET_PIN_IDX])
      wt(1);
      holdLow <= 1'b1;
      resetLow <= 1'b1;
      wt(3);
      #1;
      `CHK("chipReset", 1'b1, chipReset)
      wt(1);
      resetLow <= 1'b0;
      wt(1);
      waitIdle();
      `CHK("backgroundMode", 1'b0, backgroundMode)
      `CHK("resetPinEnable", 1'b1, resetPinEnable)
      wt(1);
      por(1'b0);
      #1;
      `CHK("resetPinEnable", 1'b0, resetPinEnable)
      wt(1);
      por(1'b1);
      #1;
      `CHK("backgroundMode", 1'b1, backgroundMode)
      `CHK("resetPinEnable", 1'b1, resetPinEnable)
      wt(1);
      test_done();
   end
endmodule
